// *** vtm_ctrl.sv ***
`timescale 1ns/1ps
`include "vtm_defs.svh"
//
// Contract
// - i2c slave only, address 0x62, 100k
// - after brief init, idle awaiting host
// - no recognition until trained and loaded
// - training captures three utterances as templates
// - phrases up to about 1.5 seconds
// - templates readable and writable by host
// - one active template set at once
// - listen, extract on speech, match asserts wake
// - after comparison return to listening
// - memory volatile, cleared at reset
// - wake polarity and duration host configured
// - analog default; pdm drives clock, samples data
// - frames gathered continuously alongside processing
// - pdm clock pull-up off when pdm enabled
// - identity query returns chip id
module vtm_ctrl
  import vtm_pkg::*;
#(
  parameter int unsigned TMPL_PER    = 16,
  parameter int unsigned IMG_BYTES   = 1024,
  parameter logic [15:0] CHIP_ID     = 16'hA5C3, // arbitrary value
  parameter int unsigned UTT_MAX_CYC = `VTM_UTT_MAX_MS *
                                       (`VTM_NS_PER_MS / `VTM_CLK_PERIOD_NS)
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        pdm_mic_data_in,
  output logic             pdm_mic_clock_out,
  output logic             pdm_clk_oe,
  output logic             pdm_clk_pullup_en,
  input  wire logic        adc_valid,
  input  wire logic [7:0]  adc_data,
  input  wire logic        speech_det,
  input  wire logic        feat_valid,
  input  wire logic [7:0]  feat_data,
  input  wire logic        feat_done,
  input  wire logic        feat_match,
  output logic             wake_out,
  output vtm_mode_t        mode,
  output logic             low_power,
  output logic             feat_run,
  output logic             trained,
  output logic             img_loaded,
  output logic             mode_err,
  output vtm_img_wr_t      img_wr,
  output logic             frame_valid,
  output logic [7:0]       frame_data
);
  localparam int unsigned TMPL_BYTES = `VTM_UTT_COUNT * TMPL_PER;
  localparam int unsigned IW         = $clog2(TMPL_BYTES + 1);
  localparam int unsigned UTT_W      = $clog2(UTT_MAX_CYC + 1);
  localparam int unsigned INIT_CYC   = `VTM_INIT_NS / `VTM_CLK_PERIOD_NS;
  localparam int unsigned INIT_W     = $clog2(INIT_CYC + 1);
  localparam int unsigned PDM_W      = $clog2(`VTM_PDM_HALF_CYC + 1);

  typedef struct packed {
    logic [1:0]                  scl_s;
    logic [1:0]                  sda_s;
    logic [1:0]                  pdm_s;
    logic                        scl_d;
    logic                        sda_d;
    vtm_i2c_t                    i2c;
    logic [2:0]                  bit_cnt;
    logic [7:0]                  shreg;
    logic                        full;
    logic                        rw;
    logic                        sda_oe;
    logic                        first;
    logic [7:0]                  cmd;
    logic [7:0]                  tx;
    logic [IW-1:0]               rd_ptr;
    logic [IW-1:0]               wr_ptr;
    vtm_mode_t                   mode;
    logic [INIT_W-1:0]           init_cnt;
    logic                        img_loaded;
    logic                        trained;
    logic                        mode_err;
    logic [1:0]                  utt;
    logic [IW-1:0]               feat_ptr;
    logic [IW-1:0]               feat_n;
    logic                        capturing;
    logic [UTT_W-1:0]            utt_cnt;
    logic [TMPL_BYTES-1:0][7:0]  tmpl;
    vtm_cfg_t                    cfg;
    logic [15:0]                 wake_cnt;
    logic                        wake_out;
    logic [PDM_W-1:0]            pdm_div;
    logic                        pdm_clk;
    logic [7:0]                  frame_sh;
    logic [2:0]                  frame_n;
    logic [7:0]                  frame;
    logic                        frame_valid;
    vtm_img_wr_t                 img;
    logic [15:0]                 img_cnt;
  } vtm_state_t;

  vtm_state_t st_r;
  vtm_state_t st_nxt;
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;

  // ========================================================
  // read data selection
  function automatic logic [7:0] vtm_rd_byte(
    input logic [7:0]                 cmd,
    input logic [IW-1:0]              ptr,
    input logic [TMPL_BYTES-1:0][7:0] tm
  );
    logic [7:0] b;
    b = `VTM_RD_FILL;
    if (cmd == `VTM_CMD_READ_TMPL && ptr < IW'(TMPL_BYTES))
      b = tm[ptr];
    else if (cmd == `VTM_CMD_IDENT)
      b = (ptr == '0) ? CHIP_ID[15:8] : CHIP_ID[7:0];
    return b;
  endfunction

  assign scl      = st_r.scl_s[1];
  assign sda      = st_r.sda_s[1];
  assign scl_rise = scl & ~st_r.scl_d;
  assign scl_fall = ~scl & st_r.scl_d;
  assign start    = scl & st_r.scl_d & ~sda & st_r.sda_d;
  assign stop     = scl & st_r.scl_d & sda & ~st_r.sda_d;

  // ========================================================
  // next state
  always_comb begin
    logic       take;
    logic [7:0] rb;
    take = 1'b0;
    rb   = vtm_rd_byte(st_r.cmd, st_r.rd_ptr, st_r.tmpl);
    st_nxt = st_r;
    st_nxt.img.valid   = 1'b0;
    st_nxt.frame_valid = 1'b0;
    st_nxt.scl_s = {st_r.scl_s[0], scl_in};
    st_nxt.sda_s = {st_r.sda_s[0], sda_in};
    st_nxt.pdm_s = {st_r.pdm_s[0], pdm_mic_data_in};
    st_nxt.scl_d = scl;
    st_nxt.sda_d = sda;
    if (st_r.mode == M_INIT) begin
      st_nxt.init_cnt = st_r.init_cnt + INIT_W'(1);
      if (st_r.init_cnt == INIT_W'(INIT_CYC - 1))
        st_nxt.mode = M_IDLE;
    end
    // i2c slave, sampled by the system clock
    if (start) begin
      st_nxt.i2c     = I_ADDR;
      st_nxt.bit_cnt = 3'h0;
      st_nxt.full    = 1'b0;
      st_nxt.sda_oe  = 1'b0;
    end else if (stop) begin
      st_nxt.i2c    = I_IDLE;
      st_nxt.sda_oe = 1'b0;
    end else if (st_r.mode != M_INIT) begin
      unique case (st_r.i2c)
        I_IDLE: ;
        I_ADDR, I_WR: begin
          if (scl_rise) begin
            st_nxt.shreg   = {st_r.shreg[6:0], sda};
            st_nxt.full    = (st_r.bit_cnt == 3'h7);
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
          end
          if (scl_fall && st_r.full) begin
            st_nxt.full = 1'b0;
            if (st_r.i2c == I_ADDR) begin
              if (st_r.shreg[7:1] == `VTM_I2C_ADDR) begin
                st_nxt.sda_oe = 1'b1;
                st_nxt.rw     = st_r.shreg[0];
                st_nxt.i2c    = I_ACK_ADDR;
              end else begin
                st_nxt.i2c = I_IDLE;
              end
            end else begin
              st_nxt.sda_oe = 1'b1;
              st_nxt.i2c    = I_ACK_WR;
              take          = 1'b1;
            end
          end
        end
        I_ACK_ADDR: if (scl_fall) begin
          st_nxt.bit_cnt = 3'h0;
          if (st_r.rw) begin
            st_nxt.i2c    = I_RD;
            st_nxt.tx     = rb;
            st_nxt.sda_oe = ~rb[7];
            st_nxt.rd_ptr = st_r.rd_ptr + IW'(1);
          end else begin
            st_nxt.i2c    = I_WR;
            st_nxt.sda_oe = 1'b0;
            st_nxt.first  = 1'b1;
          end
        end
        I_ACK_WR: if (scl_fall) begin
          st_nxt.sda_oe  = 1'b0;
          st_nxt.i2c     = I_WR;
          st_nxt.bit_cnt = 3'h0;
        end
        I_RD: if (scl_fall) begin
          if (st_r.bit_cnt == 3'h7) begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.i2c    = I_RD_ACK;
          end else begin
            st_nxt.tx      = {st_r.tx[6:0], 1'b0};
            st_nxt.sda_oe  = ~st_r.tx[6];
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
          end
        end
        I_RD_ACK: begin
          if (scl_rise) begin
            st_nxt.full = ~sda;
            if (sda)
              st_nxt.i2c = I_IDLE;
          end
          if (scl_fall && st_r.full) begin
            st_nxt.full    = 1'b0;
            st_nxt.i2c     = I_RD;
            st_nxt.bit_cnt = 3'h0;
            st_nxt.tx      = rb;
            st_nxt.sda_oe  = ~rb[7];
            st_nxt.rd_ptr  = st_r.rd_ptr + IW'(1);
          end
        end
        default: st_nxt.i2c = I_IDLE;
      endcase
    end
    // wake timer
    if (st_r.wake_cnt != 16'h0000)
      st_nxt.wake_cnt = st_r.wake_cnt - 16'h0001;
    // operating modes
    unique case (st_r.mode)
      M_INIT, M_IDLE: ;
      M_TRAIN: begin
        if (!st_r.capturing && speech_det) begin
          st_nxt.capturing = 1'b1;
          st_nxt.utt_cnt   = '0;
          st_nxt.feat_n    = '0;
        end
        if (st_r.capturing) begin
          st_nxt.utt_cnt = st_r.utt_cnt + UTT_W'(1);
          if (feat_valid && st_r.feat_n < IW'(TMPL_PER)) begin
            st_nxt.tmpl[st_r.feat_ptr] = feat_data;
            st_nxt.feat_ptr = st_r.feat_ptr + IW'(1);
            st_nxt.feat_n   = st_r.feat_n + IW'(1);
          end
          if (feat_done || st_r.utt_cnt == UTT_W'(UTT_MAX_CYC - 1)) begin
            st_nxt.capturing = 1'b0;
            st_nxt.utt_cnt   = '0;
            st_nxt.utt       = st_r.utt + 2'h1;
            st_nxt.feat_ptr  = IW'((st_r.utt + 2'h1) * TMPL_PER);
            if (st_r.utt == 2'(`VTM_UTT_COUNT - 1)) begin
              st_nxt.trained = 1'b1;
              st_nxt.mode    = M_IDLE;
            end
          end
        end
      end
      M_LISTEN: if (speech_det) begin
        st_nxt.mode    = M_EXTRACT;
        st_nxt.utt_cnt = '0;
      end
      M_EXTRACT: begin
        st_nxt.utt_cnt = st_r.utt_cnt + UTT_W'(1);
        if (feat_done) begin
          st_nxt.mode = M_LISTEN;
          if (feat_match)
            st_nxt.wake_cnt = {st_r.cfg.wake_dur,
                               `VTM_WAKE_UNIT_LO};
        end else if (st_r.utt_cnt == UTT_W'(UTT_MAX_CYC - 1)) begin
          st_nxt.mode    = M_LISTEN;
          st_nxt.utt_cnt = '0;
        end
      end
    endcase
    // host byte handling
    if (take) begin
      if (st_r.first) begin
        st_nxt.first  = 1'b0;
        st_nxt.cmd    = st_r.shreg;
        st_nxt.rd_ptr = '0;
        st_nxt.wr_ptr = '0;
      end else begin
        case (st_r.cmd)
          `VTM_CMD_SET_MODE: begin
            st_nxt.mode_err = 1'b0;
            if (st_r.shreg == `VTM_MODE_TRAIN) begin
              st_nxt.mode      = M_TRAIN;
              st_nxt.utt       = 2'h0;
              st_nxt.trained   = 1'b0;
              st_nxt.feat_ptr  = '0;
              st_nxt.capturing = 1'b0;
            end else if (st_r.shreg == `VTM_MODE_RECOG) begin
              if (st_r.img_loaded && st_r.trained)
                st_nxt.mode = M_LISTEN;
              else
                st_nxt.mode_err = 1'b1;
            end else begin
              st_nxt.mode = M_IDLE;
            end
          end
          `VTM_CMD_LOAD_IMAGE: begin
            st_nxt.img     = '{1'b1, st_r.img_cnt, st_r.shreg};
            st_nxt.img_cnt = st_r.img_cnt + 16'h0001;
            if (st_r.img_cnt == 16'(IMG_BYTES - 1))
              st_nxt.img_loaded = 1'b1;
          end
          `VTM_CMD_WRITE_TMPL: begin
            st_nxt.tmpl[st_r.wr_ptr] = st_r.shreg;
            st_nxt.wr_ptr = st_r.wr_ptr + IW'(1);
            if (st_r.wr_ptr == IW'(TMPL_BYTES - 1)) begin
              st_nxt.trained = 1'b1;
              st_nxt.wr_ptr  = '0;
            end
          end
          `VTM_CMD_WAKE_CFG: begin
            if (st_r.wr_ptr == '0)
              st_nxt.cfg.wake_pol = st_r.shreg[0];
            else
              st_nxt.cfg.wake_dur = st_r.shreg;
            st_nxt.wr_ptr = IW'(1);
          end
          `VTM_CMD_MIC_CFG: st_nxt.cfg.pdm_en = st_r.shreg[0];
          default: ;
        endcase
      end
    end
    st_nxt.wake_out = (st_nxt.wake_cnt != 16'h0000) ?
                      st_nxt.cfg.wake_pol : ~st_nxt.cfg.wake_pol;
    // frame gathering, runs beside extraction
    st_nxt.pdm_div = '0;
    st_nxt.pdm_clk = 1'b0;
    if (st_r.cfg.pdm_en) begin
      st_nxt.pdm_div = st_r.pdm_div + PDM_W'(1);
      st_nxt.pdm_clk = st_r.pdm_clk;
      if (st_r.pdm_div == PDM_W'(`VTM_PDM_HALF_CYC - 1)) begin
        st_nxt.pdm_div = '0;
        st_nxt.pdm_clk = ~st_r.pdm_clk;
        if (!st_r.pdm_clk && st_r.mode > M_IDLE) begin
          st_nxt.frame_sh = {st_r.frame_sh[6:0], st_r.pdm_s[1]};
          st_nxt.frame_n  = st_r.frame_n + 3'h1;
          if (st_r.frame_n == 3'h7) begin
            st_nxt.frame       = {st_r.frame_sh[6:0], st_r.pdm_s[1]};
            st_nxt.frame_valid = 1'b1;
          end
        end
      end
    end else if (adc_valid && st_r.mode > M_IDLE) begin
      st_nxt.frame       = adc_data;
      st_nxt.frame_valid = 1'b1;
    end
  end

  // ========================================================
  // state register; reset clears all memory
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r          <= '0;
      st_r.scl_s    <= 2'h3;
      st_r.sda_s    <= 2'h3;
      st_r.scl_d    <= 1'b1;
      st_r.sda_d    <= 1'b1;
      st_r.cfg      <= '{1'b1, 8'h01, 1'b0};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ========================================================
  // outputs
  assign sda_out           = 1'b0;
  assign sda_oe            = st_r.sda_oe;
  assign pdm_mic_clock_out = st_r.pdm_clk;
  assign pdm_clk_oe        = st_r.cfg.pdm_en;
  assign pdm_clk_pullup_en = ~st_r.cfg.pdm_en;
  assign wake_out          = st_r.wake_out;
  assign mode              = st_r.mode;
  assign low_power         = (st_r.mode == M_LISTEN);
  assign feat_run          = st_r.capturing | (st_r.mode == M_EXTRACT);
  assign trained           = st_r.trained;
  assign img_loaded        = st_r.img_loaded;
  assign mode_err          = st_r.mode_err;
  assign img_wr            = st_r.img;
  assign frame_valid       = st_r.frame_valid;
  assign frame_data        = st_r.frame;

  // ========================================================
  // checks
  function automatic logic take_mode_cmd();
    return st_r.i2c == I_WR && st_r.cmd == `VTM_CMD_SET_MODE;
  endfunction

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_addr_ack: assert property (
    ce && st_r.i2c == I_ADDR && scl_fall && st_r.full && !start && !stop
    |=> sda_oe == ($past(st_r.shreg[7:1]) == `VTM_I2C_ADDR))
    else $error("address ack wrong");
  a_init_idle: assert property (
    ce && st_r.mode == M_INIT && st_r.init_cnt == INIT_W'(INIT_CYC - 1)
    |=> st_r.mode == M_IDLE) else $error("init did not end");
  a_recog_guard: assert property (
    ce && st_r.mode != M_LISTEN && st_nxt.mode == M_LISTEN
    && st_r.mode != M_EXTRACT |-> st_r.trained && st_r.img_loaded)
    else $error("recognition entered untrained");
  a_train_three: assert property (
    $rose(st_r.trained) |-> st_r.utt == 2'h3
    || st_r.cmd == `VTM_CMD_WRITE_TMPL) else $error("training count");
  a_utt_limit: assert property (
    st_r.utt_cnt < UTT_W'(UTT_MAX_CYC)) else $error("phrase too long");
  a_match_wake: assert property (
    ce && st_r.mode == M_EXTRACT && feat_done && feat_match
    |=> wake_out == st_r.cfg.wake_pol [*2]) else $error("no wake on match");
  a_back_listen: assert property (
    ce && st_r.mode == M_EXTRACT && feat_done && !take_mode_cmd()
    |=> st_r.mode == M_LISTEN) else $error("no return to listen");
  a_wake_release: assert property (
    ce && st_r.wake_cnt == 16'h0001 && st_nxt.wake_cnt == 16'h0000
    |=> wake_out == ~st_r.cfg.wake_pol) else $error("wake stuck");
  a_pdm_pullup: assert property (
    pdm_clk_oe |-> !pdm_clk_pullup_en ##1 (pdm_clk_oe || !$past(ce)
    || pdm_clk_pullup_en)) else $error("pull-up on with pdm");
endmodule

// *** vtm_defs.svh ***
`ifndef VTM_DEFS_SVH
`define VTM_DEFS_SVH
// ==========================================================
// bus address and commands
`define VTM_I2C_ADDR        7'h62
`define VTM_I2C_MAX_KBPS    100
`define VTM_CMD_SET_MODE    8'h01
`define VTM_CMD_LOAD_IMAGE  8'h02
`define VTM_CMD_WRITE_TMPL  8'h03
`define VTM_CMD_READ_TMPL   8'h04
`define VTM_CMD_WAKE_CFG    8'h05
`define VTM_CMD_MIC_CFG     8'h06
`define VTM_CMD_IDENT       8'h07
`define VTM_MODE_IDLE       8'h00
`define VTM_MODE_TRAIN      8'h01
`define VTM_MODE_RECOG      8'h02
`define VTM_RD_FILL         8'hFF
`define VTM_WAKE_UNIT_LO    8'hFF
// ==========================================================
// timing
`define VTM_CLK_PERIOD_NS   4
`define VTM_INIT_NS         1000
`define VTM_UTT_MAX_MS      1500
`define VTM_NS_PER_MS       1000000
`define VTM_UTT_COUNT       3
`define VTM_PDM_HALF_CYC    40
`endif

// *** vtm_pkg.sv ***
package vtm_pkg;
  // ========================================================
  // modes and bus states
  typedef enum logic [2:0] {
    M_INIT    = 3'b000,
    M_IDLE    = 3'b001,
    M_TRAIN   = 3'b010,
    M_LISTEN  = 3'b011,
    M_EXTRACT = 3'b100
  } vtm_mode_t;

  typedef enum logic [2:0] {
    I_IDLE     = 3'b000,
    I_ADDR     = 3'b001,
    I_ACK_ADDR = 3'b010,
    I_WR       = 3'b011,
    I_ACK_WR   = 3'b100,
    I_RD       = 3'b101,
    I_RD_ACK   = 3'b110
  } vtm_i2c_t;

  // ========================================================
  // carriers
  typedef struct packed {
    logic       wake_pol;
    logic [7:0] wake_dur;
    logic       pdm_en;
  } vtm_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } vtm_img_wr_t;
endpackage

// *** vtm_host_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// i2c host and pdm microphone
module vtm_host_model (
  input  wire logic        clk_sys,
  output logic             scl_in,
  output logic             sda_in,
  input  wire logic        sda_oe,
  input  wire logic        pdm_mic_clock_out,
  input  wire logic        pdm_clk_oe,
  output logic             pdm_mic_data_in,
  output logic             rd_stb,
  output logic [7:0]       rd_byte
);
  logic       sda_h = 1'b1;
  logic       ck_q  = 1'b0;
  logic [7:0] lfsr  = 8'hB5;
  initial begin
    scl_in  = 1'b1;
    rd_stb  = 1'b0;
    rd_byte = 8'h00;
  end
  // open drain with pull-up, bus level seen by both sides
  assign sda_in          = sda_h & ~sda_oe;
  assign pdm_mic_data_in = lfsr[0];
  // mic data moves on clock fall; churns while clock is off
  always @(posedge clk_sys) begin
    ck_q <= pdm_mic_clock_out;
    if (!pdm_clk_oe || (ck_q && !pdm_mic_clock_out)) begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end
  // start or repeated start, data falls while clock high
  task automatic start();
    #31 sda_h = 1'b1;
    #31 scl_in = 1'b1;
    #63 sda_h = 1'b0;
    #63 scl_in = 1'b0;
  endtask
  task automatic stop();
    #31 sda_h = 1'b0;
    #31 scl_in = 1'b1;
    #63 sda_h = 1'b1;
    #63;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      #31 sda_h = b[i];
      #31 scl_in = 1'b1;
      #63 scl_in = 1'b0;
    end
    #31 sda_h = 1'b1;
    #31 scl_in = 1'b1;
    ack_n = sda_in;
    #63 scl_in = 1'b0;
  endtask
  // last byte is answered with a nack to end the read
  task automatic rbyte(input logic last, output logic [7:0] b);
    sda_h = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #62 scl_in = 1'b1;
      b[i] = sda_in;
      #63 scl_in = 1'b0;
    end
    #31 sda_h = last;
    #31 scl_in = 1'b1;
    #63 scl_in = 1'b0;
    rd_byte = b;
    rd_stb  = 1'b1;
    #1 rd_stb = 1'b0;
  endtask
endmodule

// *** voice_trigger_mode_control_tb_top.sv ***
`timescale 1ns/1ps
// ==========================================================
// bench top
module voice_trigger_mode_control_tb_top;
  import vtm_pkg::*;
  localparam int TP = 2;
  localparam int IB = 4;
  logic        clk_sys, rst, ce, sda_out, sda_oe, rd_stb, ack_n, c0;
  logic        scl_in, sda_in, pdm_mic_data_in, pdm_mic_clock_out;
  logic        pdm_clk_oe, pdm_clk_pullup_en, adc_valid, speech_det;
  logic        feat_valid, feat_done, feat_match, wake_out, low_power;
  logic        feat_run, trained, img_loaded, mode_err, frame_valid;
  logic        wake_idle, wake_arm;
  logic [7:0]  adc_data, feat_data, frame_data, rd_byte, adc_p;
  logic [7:0]  rd_q[$];
  logic [7:0]  d[$];
  logic [7:0]  tm[3*TP];
  logic [23:0] img_q[$];
  vtm_mode_t   mode;
  vtm_img_wr_t img_wr;
  int          wake_q[$];
  int          mismatches, checks_done, wcnt, seed, k;

  vtm_ctrl #(.TMPL_PER(TP), .IMG_BYTES(IB), .CHIP_ID(16'h3C5A),
    .UTT_MAX_CYC(200)) u_vtm_ctrl (.clk_sys, .rst, .ce, .scl_in, .sda_in,
    .sda_out, .sda_oe, .pdm_mic_data_in, .pdm_mic_clock_out, .pdm_clk_oe,
    .pdm_clk_pullup_en, .adc_valid, .adc_data, .speech_det, .feat_valid,
    .feat_data, .feat_done, .feat_match, .wake_out, .mode, .low_power,
    .feat_run, .trained, .img_loaded, .mode_err, .img_wr, .frame_valid,
    .frame_data);
  vtm_host_model u_vtm_host_model (.clk_sys, .scl_in, .sda_in, .sda_oe,
    .pdm_mic_clock_out, .pdm_clk_oe, .pdm_mic_data_in, .rd_stb, .rd_byte);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // checks and verdict
  task automatic cmp_v(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_n(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      mismatches++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic fail_out();
    mismatches++;
    $display("ERROR %0t wait ran out", $time);
    print_verdict();
  endtask
  task automatic tick1();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_mode(input vtm_mode_t m, input int n);
    for (k = 0; k < n && mode !== m; k++) tick1();
    if (mode !== m) fail_out();
    cmp_v(mode, m);
  endtask
  // ==========================================================
  // host transfers
  task automatic wr_cmd(input logic [7:0] c);
    u_vtm_host_model.start();
    u_vtm_host_model.wbyte(8'hC4, ack_n);
    cmp_v(ack_n, 0);
    u_vtm_host_model.wbyte(c, ack_n);
    foreach (d[i]) u_vtm_host_model.wbyte(d[i], ack_n);
    u_vtm_host_model.stop();
    d = {};
  endtask
  task automatic rd_cmd(input logic [7:0] c, input int n);
    logic [7:0] b;
    u_vtm_host_model.start();
    u_vtm_host_model.wbyte(8'hC4, ack_n);
    u_vtm_host_model.wbyte(c, ack_n);
    u_vtm_host_model.start();
    u_vtm_host_model.wbyte(8'hC5, ack_n);
    for (int i = 0; i < n; i++) u_vtm_host_model.rbyte(i == n - 1, b);
    u_vtm_host_model.stop();
  endtask
  task automatic recog(input logic m, input int len);
    @(posedge clk_sys);
    speech_det <= 1'b1;
    wait_mode(M_EXTRACT, 3);
    cmp_v({feat_run, low_power}, 2'b10);
    @(posedge clk_sys);
    speech_det <= 1'b0;
    feat_done  <= 1'b1;
    feat_match <= m;
    if (m) wake_q.push_back(len);
    @(posedge clk_sys);
    feat_done  <= 1'b0;
    feat_match <= 1'b0;
    wait_mode(M_LISTEN, 3);
    cmp_v({feat_run, low_power}, 2'b01);
    repeat (len + 20) @(posedge clk_sys);
  endtask
  // ==========================================================
  // result watchers
  always @(posedge rd_stb)
    cmp_v(rd_byte, rd_q.size() > 0 ? rd_q.pop_front() : 'x);
  always @(posedge clk_sys) begin
    adc_valid <= 1'($random(seed));
    adc_data  <= 8'($random(seed));
    adc_p     <= adc_data;
    if (frame_valid === 1'b1 && pdm_clk_oe === 1'b0)
      cmp_v(frame_data, adc_p);
    if (img_wr.valid === 1'b1)
      cmp_v({img_wr.addr, img_wr.data}, img_q.pop_front());
    if (wake_arm && wake_out !== wake_idle) begin
      wcnt <= wcnt + 1;
    end else if (wcnt > 0) begin
      cmp_n(wcnt, wake_q.size() > 0 ? wake_q.pop_front() : -1);
      wcnt <= 0;
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h34E9C339;
    {rst, ce, speech_det, feat_valid, feat_done, feat_match} = 6'h30;
    {adc_valid, adc_data, feat_data} = 17'h00000;
    {wake_idle, wake_arm, wcnt, mismatches, checks_done} = '0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    tick1();
    cmp_v(mode, M_INIT);
    cmp_v({sda_out, sda_oe, wake_out, pdm_clk_oe, pdm_clk_pullup_en},
      5'b00001);
    wait_mode(M_IDLE, 300);
    u_vtm_host_model.start();
    u_vtm_host_model.wbyte(8'hA0, ack_n);
    cmp_v(ack_n, 1);
    u_vtm_host_model.stop();
    rd_q = {8'h3C, 8'h5A, 8'hFF};
    rd_cmd(8'h07, 2);
    rd_cmd(8'h09, 1);
    for (int i = 0; i < IB; i++) begin
      d.push_back(8'($random(seed)));
      img_q.push_back({16'(i), d[i]});
    end
    wr_cmd(8'h02);
    cmp_v({img_loaded, trained}, 2'b10);
    d = {8'h02};
    wr_cmd(8'h01);
    cmp_v({mode_err, mode}, {1'b1, M_IDLE});
    d = {8'h01};
    wr_cmd(8'h01);
    wait_mode(M_TRAIN, 50);
    for (int u = 0; u < 3; u++) begin
      cmp_v(trained, 0);
      @(posedge clk_sys);
      speech_det <= 1'b1;
      for (int j = 0; j < TP; j++) begin
        @(posedge clk_sys);
        tm[u*TP+j] = 8'($random(seed));
        feat_valid <= 1'b1;
        feat_data  <= tm[u*TP+j];
      end
      @(posedge clk_sys);
      {feat_valid, feat_done, speech_det} <= 3'b010;
      @(posedge clk_sys);
      feat_done <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    wait_mode(M_IDLE, 20);
    cmp_v(trained, 1);
    foreach (tm[i]) rd_q.push_back(tm[i]);
    rd_cmd(8'h04, 3*TP);
    foreach (tm[i]) begin
      tm[i] = 8'($random(seed));
      d.push_back(tm[i]);
      rd_q.push_back(tm[i]);
    end
    wr_cmd(8'h03);
    rd_cmd(8'h04, 3*TP);
    d = {8'h00, 8'h00};
    wr_cmd(8'h05);
    wake_idle <= 1'b1;
    tick1();
    cmp_v(wake_out, 1);
    d = {8'h02};
    wr_cmd(8'h01);
    wait_mode(M_LISTEN, 50);
    wake_arm <= 1'b1;
    recog(1'b1, 255);
    recog(1'b0, 0);
    wake_arm <= 1'b0;
    d = {8'h01, 8'h01};
    wr_cmd(8'h05);
    wake_idle <= 1'b0;
    wake_arm  <= 1'b1;
    recog(1'b1, 511);
    cmp_n(wake_q.size(), 0);
    for (int i = 0; i < IB; i++) begin
      d.push_back(8'($random(seed)));
      img_q.push_back({16'(IB + i), d[i]});
    end
    wr_cmd(8'h02);
    d = {8'h01};
    wr_cmd(8'h06);
    tick1();
    cmp_v({pdm_clk_oe, pdm_clk_pullup_en}, 2'b10);
    for (int e = 0; e < 2; e++) begin
      c0 = pdm_mic_clock_out;
      for (k = 0; k < 100 && pdm_mic_clock_out === c0; k++) tick1();
    end
    cmp_n(k, 40);
    for (k = 0; k < 800 && frame_valid !== 1'b1; k++) tick1();
    cmp_v(frame_valid, 1);
    @(posedge clk_sys);
    ce <= 1'b0;
    tick1();
    c0 = pdm_mic_clock_out;
    repeat (40) tick1();
    cmp_v(pdm_mic_clock_out, c0);
    @(posedge clk_sys);
    ce <= 1'b1;
    d = {8'h00};
    wr_cmd(8'h01);
    cmp_v({feat_run, low_power, mode}, {2'b00, M_IDLE});
    wake_arm <= 1'b0;
    rst      <= 1'b1;
    repeat (3) tick1();
    cmp_v({mode, trained, img_loaded, pdm_clk_pullup_en}, 6'h01);
    print_verdict();
  end
endmodule
